// [cfg_decoder_pkg.sv]
// Constants, register map and configuration word layout for the configuration decoder
package cfg_decoder_pkg;

	// ==================================================
	// Clock and timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int WAIT_UNIT_NS = 12_500_000;
	localparam int WAIT_UNIT_CYCLES = WAIT_UNIT_NS / CLK_PERIOD_NS;
	localparam int SRST_PULSE_NS = 5_000;
	localparam int SRST_PULSE_CYCLES = (SRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCL_QUARTER_NS = 1_248;
	localparam int SCL_QUARTER_CYCLES = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FORMAT_SECTORS = 10;

	// ==================================================
	// Register map (byte addresses)
	localparam logic [11:0] REG_STATUS = 12'h000;
	localparam logic [11:0] REG_CONTROL = 12'h004;
	localparam logic [11:0] REG_OPQUERY = 12'h008;
	localparam logic [11:0] REG_XADDR = 12'h00C;
	localparam logic [11:0] REG_XDATA = 12'h010;
	localparam logic [11:0] PRAM_BASE = 12'h400;
	localparam logic [11:0] CFG_WORD_OFS = 12'h4DC;
	localparam logic [11:0] MAP_BASE_OFS = 12'h4E0;
	localparam logic [11:0] MAP_80_9F_OFS = 12'h4F0;
	localparam logic [11:0] MAP_A0_BF_OFS = 12'h4F4;
	localparam logic [11:0] MAP_C0_DF_OFS = 12'h4F8;
	localparam logic [11:0] MAP_E0_FF_OFS = 12'h4FC;
	localparam int PRAM_WORDS = 64;

	// Control register bits
	localparam int CTL_RELOAD_BIT = 0;
	localparam int CTL_CLR_ERR_BIT = 1;
	localparam int CTL_FETCH_BIT = 2;

	// ==================================================
	// Configuration word fields
	localparam int CFG_PW_BIT = 31;
	localparam int CFG_MD_BIT = 30;
	localparam int CFG_WAIT_BIT = 29;
	localparam int CFG_SR_BIT = 28;
	localparam int CFG_LI_BIT = 27;
	localparam int CFG_FU_BIT = 26;
	localparam int CFG_MO_BIT = 25;
	localparam int CFG_WTIME_LSB = 0;
	localparam int CFG_WTIME_W = 8;

	// ==================================================
	// Built-in per-opcode transfer modes, word 0 covers opcodes 00h-1Fh
	localparam logic [7:0][31:0] DEFAULT_MAP = {
		32'h4000_0000, 32'h0000_0000, 32'h04A0_0042, 32'h0000_0000,
		32'h0000_0000, 32'h0500_0000, 32'h00A0_0000, 32'h0000_0000};

	// ==================================================
	// Serial EEPROM
	localparam logic [6:0] EE_DEV_ADDR = 7'h50;
	localparam logic [15:0] EE_IMAGE_BASE = 16'h0000;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage

// [serial_word_reader.sv]
// Two-wire serial bus master that reads one 32-bit big-endian word from an EEPROM
`timescale 1ns/1ps
module serial_word_reader #(
	parameter int QUARTER_CYCLES = cfg_decoder_pkg::SCL_QUARTER_CYCLES
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Request
	input wire logic start,
	input wire logic [15:0] byte_addr,
	output logic busy,
	output logic done,
	output logic ack_error,
	output logic [31:0] word,
	// Bus pins
	output logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	import cfg_decoder_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_WBIT, ST_WACK, ST_RSTART, ST_RBIT, ST_RACK, ST_STOP} rd_state_t;

	rd_state_t state_reg;
	logic [15:0] div_reg;
	logic [1:0] q_reg;
	logic [2:0] bit_reg;
	logic [1:0] wbyte_reg;
	logic [1:0] rbyte_reg;
	logic [7:0] sh_reg;
	logic [15:0] addr_reg;
	logic sda_s1_reg;
	logic sda_s2_reg;
	logic scl_next;
	logic tick;

	assign tick = (div_reg == 16'(QUARTER_CYCLES - 1));
	assign busy = (state_reg != ST_IDLE);
	assign sda_out = 1'b0;

	// SCL high in the last two quarters of a bit; SDA only moves while SCL stands still
	always_comb
	begin
		unique case (state_reg)
			ST_IDLE: scl_next = 1'b1;
			ST_START: scl_next = (q_reg == 2'd0);
			ST_STOP: scl_next = (q_reg != 2'd3) ? (q_reg != 2'd0) : 1'b1;
			default: scl_next = (q_reg == 2'd1) || (q_reg == 2'd2);
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		sda_s1_reg <= sda_in;
		sda_s2_reg <= sda_s1_reg;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			state_reg <= ST_IDLE;
			div_reg <= '0;
			q_reg <= '0;
			bit_reg <= '0;
			wbyte_reg <= '0;
			rbyte_reg <= '0;
			sh_reg <= '0;
			addr_reg <= '0;
			word <= RESET_WORD;
			done <= 1'b0;
			ack_error <= 1'b0;
			scl <= 1'b1;
			sda_oe <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (state_reg == ST_IDLE)
			begin
				div_reg <= '0;
				q_reg <= '0;
				if (start)
				begin
					state_reg <= ST_START;
					addr_reg <= byte_addr;
					ack_error <= 1'b0;
				end
			end
			else if (!tick)
				div_reg <= div_reg + 16'd1;
			else
			begin
				div_reg <= '0;
				q_reg <= q_reg + 2'd1;
				scl <= scl_next;
				unique case (state_reg)
					ST_START:
					begin
						sda_oe <= 1'b1;
						if (q_reg == 2'd3)
						begin
							state_reg <= ST_WBIT;
							sh_reg <= {EE_DEV_ADDR, 1'b0};
							wbyte_reg <= 2'd0;
							bit_reg <= '0;
						end
					end
					ST_WBIT:
					begin
						if (q_reg == 2'd0)
							sda_oe <= ~sh_reg[7];
						if (q_reg == 2'd3)
						begin
							sh_reg <= {sh_reg[6:0], 1'b0};
							bit_reg <= bit_reg + 3'd1;
							if (bit_reg == 3'd7)
								state_reg <= ST_WACK;
						end
					end
					ST_WACK:
					begin
						if (q_reg == 2'd0)
							sda_oe <= 1'b0;
						if (q_reg == 2'd2 && sda_s2_reg)
							ack_error <= 1'b1;
						if (q_reg == 2'd3)
						begin
							wbyte_reg <= wbyte_reg + 2'd1;
							unique case (wbyte_reg)
								2'd0:
								begin
									sh_reg <= addr_reg[15:8];
									state_reg <= ST_WBIT;
								end
								2'd1:
								begin
									sh_reg <= addr_reg[7:0];
									state_reg <= ST_WBIT;
								end
								2'd2: state_reg <= ST_RSTART;
								2'd3:
								begin
									rbyte_reg <= 2'd0;
									state_reg <= ST_RBIT;
								end
							endcase
						end
					end
					ST_RSTART:
					begin
						sda_oe <= (q_reg >= 2'd2);
						if (q_reg == 2'd3)
						begin
							sh_reg <= {EE_DEV_ADDR, 1'b1};
							state_reg <= ST_WBIT;
						end
					end
					ST_RBIT:
					begin
						if (q_reg == 2'd0)
							sda_oe <= 1'b0;
						if (q_reg == 2'd2)
							sh_reg <= {sh_reg[6:0], sda_s2_reg};
						if (q_reg == 2'd3)
						begin
							bit_reg <= bit_reg + 3'd1;
							if (bit_reg == 3'd7)
								state_reg <= ST_RACK;
						end
					end
					ST_RACK:
					begin
						if (q_reg == 2'd0)
						begin
							sda_oe <= (rbyte_reg != 2'd3);
							word <= {word[23:0], sh_reg};
						end
						if (q_reg == 2'd3)
						begin
							rbyte_reg <= rbyte_reg + 2'd1;
							state_reg <= (rbyte_reg == 2'd3) ? ST_STOP : ST_RBIT;
						end
					end
					ST_STOP:
					begin
						sda_oe <= (q_reg <= 2'd1);
						if (q_reg == 2'd3)
						begin
							state_reg <= ST_IDLE;
							done <= 1'b1;
						end
					end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end
endmodule

// [storage_bridge_config_decoder.sv]
// Configuration image loader, option decoder, drive power-up sequencer and transfer mode selector
`timescale 1ns/1ps
// Behaviour
// - Password bit set: every host login needs password authentication
// - Mode map disabled: built-in per-opcode modes, map words may be absent
// - Per-opcode mode selection applies only to packet-command drives
// - Wait bit set: delay initialization by wait time times 12.5 ms
// - Soft reset bit set: soft reset the drive before initialization
// - Login-gated: power enable low, initialization deferred until host login
// - Login-gated: host logoff drops drive power enable again
// - Format bit set: format zeroes first and last ten sectors; here the bit only drives format_support_enable, no sectors are zeroed
// - Password bit set: password/mode field is password data, not a map
// - Map bit for opcode N: byte E0h msb is opcode 00h onward
// - Map bit one selects fastest DMA, zero selects fastest PIO
// - Both bits clear: password/mode field ignored as reserved
// - Configuration image held in on-chip RAM for host requests
// - Further image words fetched on demand from external serial ROM
// - Parameter RAM visible as one contiguous register window
module storage_bridge_config_decoder #(
	parameter int WAIT_UNIT = cfg_decoder_pkg::WAIT_UNIT_CYCLES,
	parameter int SRST_CYCLES = cfg_decoder_pkg::SRST_PULSE_CYCLES,
	parameter int QUARTER_CYCLES = cfg_decoder_pkg::SCL_QUARTER_CYCLES,
	parameter int RAM_WORDS = cfg_decoder_pkg::PRAM_WORDS
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Serial EEPROM
	output logic ee_scl,
	input wire logic ee_sda_in,
	output logic ee_sda_out,
	output logic ee_sda_oe,
	// Drive control
	input wire logic atapi_device,
	output logic drive_power_enable,
	output logic drive_soft_reset,
	output logic drive_init_start,
	// Host session events
	input wire logic login_event,
	input wire logic logoff_event,
	output logic login_auth_required,
	// Per-command transfer mode
	input wire logic [7:0] cmd_opcode,
	input wire logic cmd_valid,
	output logic cmd_mode_valid,
	output logic cmd_mode_apply,
	output logic cmd_use_dma,
	// Decoded options
	output logic format_support_enable,
	output logic magneto_optical_support,
	output logic password_field_valid,
	output logic config_error_event
);
	import cfg_decoder_pkg::*;

	typedef enum logic [2:0] {SEQ_LOAD, SEQ_LOADWAIT, SEQ_CHECK, SEQ_DELAY, SEQ_SRST, SEQ_LOGIN, SEQ_INIT,
		SEQ_RUN} seq_state_t;

	localparam int RAM_AW = $clog2(RAM_WORDS);
	localparam logic [RAM_AW-1:0] CFG_IDX = RAM_AW'((CFG_WORD_OFS - PRAM_BASE) >> 2);
	localparam logic [RAM_AW-1:0] MAP_IDX = RAM_AW'((MAP_BASE_OFS - PRAM_BASE) >> 2);
	localparam logic [RAM_AW-1:0] LAST_IDX = RAM_AW'(RAM_WORDS - 1);

	// ==================================================
	// State
	logic [31:0] pram [RAM_WORDS];
	seq_state_t seq_reg;
	logic [RAM_AW-1:0] load_idx_reg;
	logic [31:0] cfg_reg;
	logic [31:0] unit_cnt_reg;
	logic [CFG_WTIME_W-1:0] units_left_reg;
	logic cfg_err_reg;
	logic load_err_reg;
	logic loaded_reg;
	logic fetch_busy_reg;
	logic fetch_err_reg;
	logic fetch_owned_reg;
	logic [15:0] xaddr_reg;
	logic [31:0] xdata_reg;
	logic [7:0] query_op_reg;
	logic power_reg;

	// ==================================================
	// Serial reader sharing between image load and on-demand fetch
	logic rd_start;
	logic [15:0] rd_addr;
	logic rd_busy;
	logic rd_done;
	logic rd_err;
	logic [31:0] rd_word;
	logic load_issue;
	logic fetch_issue;

	assign load_issue = (seq_reg == SEQ_LOAD) && !rd_busy;
	assign fetch_issue = fetch_busy_reg && !fetch_owned_reg && !rd_busy && (seq_reg != SEQ_LOAD) &&
		(seq_reg != SEQ_LOADWAIT);
	assign rd_start = load_issue || fetch_issue;
	assign rd_addr = load_issue ? (EE_IMAGE_BASE + {load_idx_reg, 2'b00}) : xaddr_reg;

	serial_word_reader #(
		.QUARTER_CYCLES(QUARTER_CYCLES)
	) u_reader (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.start(rd_start),
		.byte_addr(rd_addr),
		.busy(rd_busy),
		.done(rd_done),
		.ack_error(rd_err),
		.word(rd_word),
		.scl(ee_scl),
		.sda_in(ee_sda_in),
		.sda_out(ee_sda_out),
		.sda_oe(ee_sda_oe)
	);

	// ==================================================
	// Option decode
	logic pw_bit;
	logic md_bit;
	logic wait_bit;
	logic sr_bit;
	logic li_bit;
	logic [CFG_WTIME_W-1:0] wait_time;
	logic [31:0] new_cfg;
	logic new_cfg_bad;

	assign pw_bit = cfg_reg[CFG_PW_BIT];
	assign md_bit = cfg_reg[CFG_MD_BIT];
	assign wait_bit = cfg_reg[CFG_WAIT_BIT];
	assign sr_bit = cfg_reg[CFG_SR_BIT];
	assign li_bit = cfg_reg[CFG_LI_BIT];
	assign wait_time = cfg_reg[CFG_WTIME_LSB +: CFG_WTIME_W];
	assign new_cfg = pram[CFG_IDX];
	assign new_cfg_bad = (new_cfg[CFG_PW_BIT] && new_cfg[CFG_MD_BIT]) ||
		(new_cfg[CFG_LI_BIT] && (new_cfg[CFG_WAIT_BIT] || new_cfg[CFG_SR_BIT]));

	// ==================================================
	// Transfer mode lookup
	logic [31:0] map_word_ram;
	logic [31:0] map_word_def;
	logic [4:0] map_bitpos;
	logic map_bit;
	logic map_bit_q;

	assign map_word_ram = pram[MAP_IDX + RAM_AW'(cmd_opcode[7:5])];
	assign map_word_def = DEFAULT_MAP[cmd_opcode[7:5]];
	assign map_bitpos = 5'd31 - cmd_opcode[4:0];
	// Password data is never read as a map; defaults rule otherwise
	assign map_bit = (md_bit && !pw_bit) ? map_word_ram[map_bitpos] : map_word_def[map_bitpos];
	assign map_bit_q = (md_bit && !pw_bit) ? pram[MAP_IDX + RAM_AW'(query_op_reg[7:5])][5'd31 - query_op_reg[4:0]]
		: DEFAULT_MAP[query_op_reg[7:5]][5'd31 - query_op_reg[4:0]];

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			cmd_mode_valid <= 1'b0;
			cmd_mode_apply <= 1'b0;
			cmd_use_dma <= 1'b0;
		end
		else
		begin
			cmd_mode_valid <= cmd_valid;
			cmd_mode_apply <= cmd_valid && atapi_device;
			cmd_use_dma <= cmd_valid && atapi_device && map_bit;
		end
	end

	// ==================================================
	// Register decode
	logic wr_ctl;
	logic wr_query;
	logic wr_xaddr;
	logic in_window;
	logic [RAM_AW-1:0] win_idx;
	logic [31:0] status_word;
	logic [31:0] rd_mux;

	assign wr_ctl = reg_wr && (reg_addr[11:2] == REG_CONTROL[11:2]);
	assign wr_query = reg_wr && (reg_addr[11:2] == REG_OPQUERY[11:2]);
	assign wr_xaddr = reg_wr && (reg_addr[11:2] == REG_XADDR[11:2]);
	assign in_window = (reg_addr >= PRAM_BASE) && ({2'b00, reg_addr[11:2]} < {2'b00, PRAM_BASE[11:2]} + 12'(RAM_WORDS));
	assign win_idx = RAM_AW'(reg_addr[11:2] - PRAM_BASE[11:2]);
	assign status_word = {20'h0_0000, fetch_err_reg, fetch_busy_reg, load_err_reg, loaded_reg, cfg_err_reg,
		power_reg, 3'(seq_reg), password_field_valid, atapi_device, md_bit && !pw_bit};
	assign rd_mux = in_window ? pram[win_idx] :
		(reg_addr[11:2] == REG_STATUS[11:2]) ? status_word :
		(reg_addr[11:2] == REG_OPQUERY[11:2]) ? {23'h00_0000, map_bit_q, query_op_reg} :
		(reg_addr[11:2] == REG_XADDR[11:2]) ? {16'h0000, xaddr_reg} :
		(reg_addr[11:2] == REG_XDATA[11:2]) ? xdata_reg : 32'h0000_0000;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
			reg_rdata <= rd_mux;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			query_op_reg <= 8'h00;
			xaddr_reg <= 16'h0000;
		end
		else
		begin
			if (wr_query)
				query_op_reg <= reg_wdata[7:0];
			if (wr_xaddr && !fetch_busy_reg)
				xaddr_reg <= reg_wdata[15:0];
		end
	end

	// ==================================================
	// On-demand fetch from the external ROM

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			fetch_busy_reg <= 1'b0;
			fetch_owned_reg <= 1'b0;
			fetch_err_reg <= 1'b0;
			xdata_reg <= RESET_WORD;
		end
		else
		begin
			if (fetch_issue)
				fetch_owned_reg <= 1'b1;
			if (rd_done && fetch_owned_reg)
			begin
				fetch_owned_reg <= 1'b0;
				fetch_busy_reg <= 1'b0;
				fetch_err_reg <= rd_err;
				xdata_reg <= rd_word;
			end
			else if (wr_ctl && reg_wdata[CTL_FETCH_BIT])
				fetch_busy_reg <= 1'b1;
		end
	end

	// ==================================================
	// Parameter RAM fill
	always_ff @(posedge sys_clk)
	begin
		if ((seq_reg == SEQ_LOADWAIT) && rd_done && !fetch_owned_reg)
			pram[load_idx_reg] <= rd_word;
	end

	// ==================================================
	// Power-up sequencer
	logic reload_req;
	logic err_clear;

	assign reload_req = wr_ctl && reg_wdata[CTL_RELOAD_BIT] && ((seq_reg == SEQ_RUN) || (seq_reg == SEQ_LOGIN));
	assign err_clear = wr_ctl && reg_wdata[CTL_CLR_ERR_BIT];

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			seq_reg <= SEQ_LOAD;
			load_idx_reg <= '0;
			cfg_reg <= RESET_WORD;
			unit_cnt_reg <= '0;
			units_left_reg <= '0;
			load_err_reg <= 1'b0;
			loaded_reg <= 1'b0;
			power_reg <= 1'b0;
			drive_soft_reset <= 1'b0;
			drive_init_start <= 1'b0;
		end
		else
		begin
			drive_init_start <= 1'b0;
			unique case (seq_reg)
				SEQ_LOAD:
					if (load_issue)
						seq_reg <= SEQ_LOADWAIT;
				SEQ_LOADWAIT:
					if (rd_done && !fetch_owned_reg)
					begin
						load_err_reg <= load_err_reg || rd_err;
						load_idx_reg <= load_idx_reg + RAM_AW'(1);
						seq_reg <= (load_idx_reg == LAST_IDX) ? SEQ_CHECK : SEQ_LOAD;
					end
				SEQ_CHECK:
				begin
					cfg_reg <= new_cfg;
					loaded_reg <= 1'b1;
					unit_cnt_reg <= '0;
					units_left_reg <= new_cfg[CFG_WTIME_LSB +: CFG_WTIME_W];
					power_reg <= !new_cfg[CFG_LI_BIT];
					if (new_cfg[CFG_LI_BIT])
						seq_reg <= SEQ_LOGIN;
					else if (new_cfg[CFG_WAIT_BIT])
						seq_reg <= SEQ_DELAY;
					else if (new_cfg[CFG_SR_BIT])
						seq_reg <= SEQ_SRST;
					else
						seq_reg <= SEQ_INIT;
				end
				SEQ_DELAY:
					if (units_left_reg == '0)
					begin
						unit_cnt_reg <= '0;
						seq_reg <= sr_bit ? SEQ_SRST : SEQ_INIT;
					end
					else if (unit_cnt_reg == 32'(WAIT_UNIT - 1))
					begin
						unit_cnt_reg <= '0;
						units_left_reg <= units_left_reg - CFG_WTIME_W'(1);
					end
					else
						unit_cnt_reg <= unit_cnt_reg + 32'd1;
				SEQ_SRST:
				begin
					drive_soft_reset <= 1'b1;
					if (unit_cnt_reg == 32'(SRST_CYCLES))
					begin
						drive_soft_reset <= 1'b0;
						seq_reg <= SEQ_INIT;
					end
					else
						unit_cnt_reg <= unit_cnt_reg + 32'd1;
				end
				SEQ_LOGIN:
				begin
					power_reg <= 1'b0;
					if (reload_req)
					begin
						load_idx_reg <= '0;
						seq_reg <= SEQ_LOAD;
					end
					else if (login_event)
					begin
						power_reg <= 1'b1;
						seq_reg <= SEQ_INIT;
					end
				end
				SEQ_INIT:
				begin
					drive_init_start <= 1'b1;
					seq_reg <= SEQ_RUN;
				end
				SEQ_RUN:
					if (reload_req)
					begin
						load_idx_reg <= '0;
						power_reg <= 1'b0;
						seq_reg <= SEQ_LOAD;
					end
					else if (li_bit && logoff_event)
					begin
						power_reg <= 1'b0;
						seq_reg <= SEQ_LOGIN;
					end
			endcase
		end
	end

	// ==================================================
	// Configuration error flag and session outputs
	logic bad_event;

	assign bad_event = (seq_reg == SEQ_CHECK) && new_cfg_bad;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			cfg_err_reg <= 1'b0;
			config_error_event <= 1'b0;
			login_auth_required <= 1'b0;
		end
		else
		begin
			config_error_event <= bad_event;
			// A new error wins over a clear in the same cycle
			cfg_err_reg <= bad_event || (cfg_err_reg && !err_clear);
			login_auth_required <= login_event && pw_bit && loaded_reg;
		end
	end

	assign drive_power_enable = power_reg;
	assign format_support_enable = cfg_reg[CFG_FU_BIT];
	assign magneto_optical_support = cfg_reg[CFG_MO_BIT];
	assign password_field_valid = pw_bit;
endmodule

// [cfg_decoder_checker_asserts.sv]
// Port-level assertions for the configuration decoder
`timescale 1ns/1ps
module cfg_decoder_checker #(
	parameter int SRST_CYCLES = 4
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [11:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Drive control
	input wire logic atapi_device,
	input wire logic drive_power_enable,
	input wire logic drive_soft_reset,
	input wire logic drive_init_start,
	// Session and mode query
	input wire logic login_event,
	input wire logic login_auth_required,
	input wire logic password_field_valid,
	input wire logic cmd_valid,
	input wire logic cmd_mode_valid,
	input wire logic cmd_mode_apply,
	input wire logic cmd_use_dma
);
	int srst_len;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !drive_soft_reset)
			srst_len <= 0;
		else
			srst_len <= srst_len + 1;
	end
	// ==================================================
	// Properties
	sequence s_srst_end;
		$fell(drive_soft_reset);
	endsequence
	property p_srst_len;
		s_srst_end |-> srst_len == SRST_CYCLES;
	endproperty
	property p_srst_init;
		s_srst_end |-> ##[0:3] drive_init_start;
	endproperty
	property p_srst_power;
		drive_soft_reset |-> drive_power_enable;
	endproperty
	property p_init_power;
		drive_init_start |-> ##[0:1] drive_power_enable;
	endproperty
	property p_mode_answer;
		cmd_valid |=> cmd_mode_valid;
	endproperty
	property p_mode_apply;
		cmd_mode_valid |-> cmd_mode_apply == $past(atapi_device) && $past(cmd_valid);
	endproperty
	property p_dma_atapi;
		cmd_use_dma |-> cmd_mode_valid && cmd_mode_apply;
	endproperty
	property p_auth;
		login_event && password_field_valid |=> login_auth_required;
	endproperty
	property p_auth_cause;
		login_auth_required |-> $past(login_event) && $past(password_field_valid);
	endproperty
	property p_unmapped;
		reg_rd && reg_addr == 12'h800 |=> reg_rdata == 32'h0000_0000;
	endproperty
	a_srst_len: assert property (p_srst_len) else $error("soft reset length wrong");
	a_srst_init: assert property (p_srst_init) else $error("no init after soft reset");
	a_srst_power: assert property (p_srst_power) else $error("soft reset unpowered");
	a_init_power: assert property (p_init_power) else $error("init without power");
	a_mode_answer: assert property (p_mode_answer) else $error("mode answer missing");
	a_mode_apply: assert property (p_mode_apply) else $error("mode apply wrong");
	a_dma_atapi: assert property (p_dma_atapi) else $error("dma on plain drive");
	a_auth: assert property (p_auth) else $error("auth not requested");
	a_auth_cause: assert property (p_auth_cause) else $error("auth without cause");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
endmodule
bind storage_bridge_config_decoder cfg_decoder_checker #(.SRST_CYCLES(SRST_CYCLES)) chk_u (.sys_clk, .sys_rst,
	.reg_addr, .reg_rd, .reg_rdata, .atapi_device, .drive_power_enable, .drive_soft_reset, .drive_init_start,
	.login_event, .login_auth_required, .password_field_valid, .cmd_valid, .cmd_mode_valid, .cmd_mode_apply,
	.cmd_use_dma);

// [ee_model.sv]
// Behavioural two-wire serial EEPROM holding the configuration image
`timescale 1ns/1ps
module ee_model
	import cfg_decoder_pkg::*;
(
	// Bus pins
	input wire logic scl,
	input wire logic sda,
	output logic sda_oe
);
	logic [31:0] img [0:63];
	logic [15:0] ptr = 16'h0000;
	logic [7:0] sh = 8'h00;
	logic act = 0;
	logic rd = 0;
	logic snd = 0;
	int bitc = 0;
	int nbyte = 0;
	initial
		sda_oe = 0;
	// ==================================================
	// Start, stop and bit handling
	always @(negedge sda)
	begin
		if (scl === 1'b1)
		begin
			act = 1;
			snd = 0;
			rd = 0;
			// The SCL fall that ends a start condition carries no data bit
			bitc = -1;
			nbyte = 0;
			sda_oe = 0;
		end
	end
	always @(posedge sda)
	begin
		if (scl === 1'b1)
			act = 0;
	end
	always @(posedge scl)
	begin
		if (act && !snd && bitc < 8)
			sh = {sh[6:0], sda};
		if (act && snd && bitc == 8 && sda)
			rd = 0;
	end
	always @(negedge scl)
	begin
		if (act && bitc == 8)
		begin
			bitc = 0;
			sda_oe = 0;
			snd = rd;
			if (rd)
			begin
				sh = img[ptr[7:2]][8 * (3 - ptr[1:0]) +: 8];
				ptr = ptr + 16'h0001;
				sda_oe = ~sh[7];
			end
		end
		else if (act)
		begin
			bitc = bitc + 1;
			if (bitc == 8 && !snd)
			begin
				if (nbyte == 0)
					rd = sh[0];
				if (nbyte == 1)
					ptr[15:8] = sh;
				if (nbyte == 2)
					ptr[7:0] = sh;
				sda_oe = nbyte > 0 || sh[7:1] == EE_DEV_ADDR;
				nbyte = nbyte + 1;
			end
			else
				sda_oe = snd && bitc < 8 && !sh[7 - bitc];
		end
	end
endmodule

// [storage_bridge_config_decoder_tb.sv]
// Self-checking bench for the configuration decoder
`timescale 1ns/1ps
module storage_bridge_config_decoder_tb;
	import cfg_decoder_pkg::*;
	logic sys_clk = 0;
	logic sys_rst = 1;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic atapi_device = 1;
	logic login_event = 0;
	logic logoff_event = 0;
	logic [7:0] cmd_opcode = 8'h00;
	logic cmd_valid = 0;
	logic err_seen = 0;
	logic [31:0] reg_rdata;
	logic ee_scl, ee_sda_out, ee_sda_oe, mdl_oe;
	logic drive_power_enable, drive_soft_reset, drive_init_start, login_auth_required;
	logic cmd_mode_valid, cmd_mode_apply, cmd_use_dma, format_support_enable;
	logic magneto_optical_support, password_field_valid, config_error_event;
	wire ee_sda = ~(ee_sda_oe | mdl_oe);
	int num_errors = 0;
	int samples_checked = 0;
	int n;
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		if (config_error_event === 1'b1)
			err_seen <= 1;
	storage_bridge_config_decoder #(.WAIT_UNIT(20), .SRST_CYCLES(4), .QUARTER_CYCLES(2), .RAM_WORDS(64)) dut_u (
		.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ee_scl, .ee_sda_in(ee_sda),
		.ee_sda_out, .ee_sda_oe, .atapi_device, .drive_power_enable, .drive_soft_reset, .drive_init_start,
		.login_event, .logoff_event, .login_auth_required, .cmd_opcode, .cmd_valid, .cmd_mode_valid,
		.cmd_mode_apply, .cmd_use_dma, .format_support_enable, .magneto_optical_support, .password_field_valid,
		.config_error_event);
	ee_model eeprom_u (.scl(ee_scl), .sda(ee_sda), .sda_oe(mdl_oe));
	// ==================================================
	// Tasks
	task conclude;
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic wait_hi(ref logic s, output int cyc);
		cyc = 0;
		while (s !== 1'b1)
		begin
			@(posedge sys_clk);
			cyc++;
			if (cyc > 90000)
			begin
				num_errors++;
				conclude();
			end
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge sys_clk);
		reg_wr <= 0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge sys_clk);
		reg_rd <= 0;
		@(negedge sys_clk);
		check(reg_rdata, exp);
	endtask
	task query(input logic [7:0] op, input logic atapi, input logic dma);
		@(posedge sys_clk);
		cmd_opcode <= op;
		atapi_device <= atapi;
		cmd_valid <= 1;
		@(posedge sys_clk);
		cmd_valid <= 0;
		@(negedge sys_clk);
		check({cmd_mode_valid, cmd_mode_apply, cmd_use_dma}, {1'b1, atapi, dma});
	endtask
	task pulse_login(input logic on);
		@(posedge sys_clk);
		login_event <= on;
		logoff_event <= !on;
		@(posedge sys_clk);
		login_event <= 0;
		logoff_event <= 0;
	endtask
	// ==================================================
	// Scenarios
	initial
	begin
		foreach (eeprom_u.img[i])
			eeprom_u.img[i] = 32'h0000_0000 + i;
		eeprom_u.img[55] = 32'h7400_0003;
		eeprom_u.img[56] = 32'h8000_0001;
		eeprom_u.img[63] = 32'h0000_0001;
		repeat (5) @(posedge sys_clk);
		sys_rst <= 0;
		wait_hi(drive_power_enable, n);
		wait_hi(drive_soft_reset, n);
		check(n >= 60 && n <= 64, 1'b1);
		wait_hi(drive_init_start, n);
		check(n >= 4 && n <= 6, 1'b1);
		rd(12'h4DC, 32'h7400_0003);
		rd(12'h414, 32'h0000_0005);
		wr(12'h4FC, 32'hFFFF_FFFF);
		rd(12'h4FC, 32'h0000_0001);
		rd(12'h800, 32'h0000_0000);
		wr(REG_XADDR, 32'h0000_0014);
		wr(REG_CONTROL, 32'h0000_0004);
		repeat (800) @(posedge sys_clk);
		rd(REG_XDATA, 32'h0000_0005);
		rd(REG_STATUS, 32'h0000_017B);
		check({format_support_enable, magneto_optical_support}, 2'b10);
		query(8'h00, 1, 1);
		query(8'h01, 1, 0);
		query(8'h1F, 1, 1);
		query(8'hFF, 1, 1);
		query(8'hFE, 1, 0);
		query(8'h00, 0, 0);
		check(err_seen, 1'b0);
		eeprom_u.img[55] = 32'hCA00_0000;
		wr(REG_CONTROL, 32'h0000_0001);
		wait_hi(err_seen, n);
		repeat (50) @(posedge sys_clk);
		check(drive_power_enable, 1'b0);
		check(password_field_valid, 1'b1);
		check({format_support_enable, magneto_optical_support}, 2'b01);
		rd(REG_STATUS, 32'h0000_01AC);
		wr(REG_CONTROL, 32'h0000_0002);
		rd(REG_STATUS, 32'h0000_012C);
		pulse_login(1);
		@(negedge sys_clk);
		check(login_auth_required, 1'b1);
		wait_hi(drive_power_enable, n);
		check(n <= 4, 1'b1);
		query(8'hE1, 1, 1);
		query(8'hFF, 1, 0);
		query(8'hA5, 1, 1);
		query(8'hA6, 1, 0);
		query(8'hBE, 1, 1);
		pulse_login(0);
		repeat (3) @(posedge sys_clk);
		check(drive_power_enable, 1'b0);
		conclude();
	end
endmodule
